// ### rtl/rxl_map.vh
// register indices, field positions, reset values and fixed counts of the receive line block
// assumes: included by the block's only design file; byte address is four times the index
`ifndef RXL_MAP_VH
`define RXL_MAP_VH

// ==========================================================
// register indices (byte address = index * 4)
`define RXL_IDX_DATA0       8'hD8
`define RXL_IDX_DATA1       8'hD9
`define RXL_IDX_DATA2       8'hDA
`define RXL_IDX_DATA3       8'hDB
`define RXL_IDX_SYS_CTRL    8'hE0
`define RXL_IDX_CFG_STAT    8'hF8
`define RXL_IDX_THR_SEL     8'hF9
`define RXL_IDX_LOSS_DECLARE_PERIOD     8'hFA
`define RXL_IDX_LOSS_RELEASE_PERIOD     8'hFB
`define RXL_IDX_EQ_RAM_INDEX     8'hFC
`define RXL_IDX_EQ_DIR      8'hFD
`define RXL_IDX_EQ_LOC      8'hFE
`define RXL_IDX_EQ_CFG      8'hFF

// ==========================================================
// field positions
`define RXL_CS_EVENT        7
`define RXL_CS_STATE        6
`define RXL_CS_IRQ_EN       5
`define RXL_CS_SQUELCH      4
`define RXL_CS_IDDQ         3
`define RXL_CS_STABLE       2
`define RXL_CS_RSVD         0
`define RXL_DIR_READ        7
`define RXL_SC_PWRDN        0
`define RXL_SC_MASTER_IDDQ  1

// ==========================================================
// reset values
`define RXL_RST_CFG_RSVD    1'b1
`define RXL_RST_PERIOD      8'h01
`define RXL_RST_READ_SEL    1'b1
`define RXL_RST_EQ_CFG      8'h03

// ==========================================================
// fixed counts
`define RXL_PERIOD_SCALE    4
`define RXL_STABLE_STEPS    8'h08
`define RXL_STABLE_BASE     9'h020

`endif

// ### rtl/rxl_los_eq.v
// receive line loss-of-signal control/status and indirect equalization ram access over apb
// assumes: one clock pclk; analog front-end signals arrive asynchronously and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "rxl_map.vh"

module rxl_los_eq (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        line_tick_in,
	input  wire [6:0]  sig_level_in,
	input  wire        rx_data_in,
	input  wire        eq_tick_in,
	input  wire [7:0]  cable_attenuation_estimate,
	output reg         irq_n,
	output reg         rx_data_out,
	output reg         rx_quiescent_test,
	output reg  [2:0]  eq_feedback_freq,
	output reg  [31:0] eq_ram_word
);

	// ==========================================================
	// state
	reg  [17:0] sync1_q;
	reg  [17:0] sync2_q;
	reg         line_tick_q;
	reg         eq_tick_q;
	reg         rx_iface_powerdown_q;
	reg         master_quiescent_test_q;
	reg         sig_loss_event_q;
	reg         sig_loss_state_q;
	reg         sig_loss_irq_enable_q;
	reg         zero_data_on_loss_enable_q;
	reg         rx_quiescent_test_enable_q;
	reg         equalizer_stable_q;
	reg         cfg_reserved_q;
	reg  [2:0]  loss_declare_threshold_q;
	reg  [2:0]  loss_release_threshold_q;
	reg  [7:0]  loss_declare_period_q;
	reg  [7:0]  loss_release_period_q;
	reg  [7:0]  eq_ram_index_q;
	reg         ram_read_not_write_q;
	reg  [7:0]  eq_location_q;
	reg  [7:0]  eq_cfg_q;
	reg  [31:0] ind_data_q;
	reg  [31:0] eq_ram_q [0:255];
	reg         access_pending_q;
	reg  [11:0] persist_cnt_q;
	reg  [7:0]  stable_ref_q;
	reg  [8:0]  stable_cnt_q;
	reg  [1:0]  rd_event_snap_q;
	reg         sig_loss_change_q;

	// ==========================================================
	// synchronised inputs
	wire        line_tick_s = sync2_q[17];
	wire        eq_tick_s   = sync2_q[16];
	wire        rx_data_s   = sync2_q[15];
	wire [6:0]  level_s     = sync2_q[14:8];
	wire [7:0]  estimate_s  = sync2_q[7:0];
	wire        line_pulse  = line_tick_s & ~line_tick_q;
	wire        eq_pulse    = eq_tick_s & ~eq_tick_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q     <= 18'h00000;
			sync2_q     <= 18'h00000;
			line_tick_q <= 1'b0;
			eq_tick_q   <= 1'b0;
		end else begin
			sync1_q     <= {line_tick_in, eq_tick_in, rx_data_in, sig_level_in, cable_attenuation_estimate};
			sync2_q     <= sync1_q;
			line_tick_q <= line_tick_s;
			eq_tick_q   <= eq_tick_s;
		end
	end

	// ==========================================================
	// apb decode
	wire        idx_ok   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
	wire [7:0]  idx      = paddr[9:2];
	wire        setup    = psel & ~penable;
	wire        commit   = psel & penable & pready;
	wire        wr_en    = commit & pwrite & ~pslverr;
	wire        rd_done  = commit & ~pwrite & ~pslverr;
	wire [7:0]  wb       = pwdata[7:0];
	wire        clr_evt  = rd_done && (idx == `RXL_IDX_CFG_STAT) && rd_event_snap_q[0];
	wire        clr_chg  = rd_done && (idx == `RXL_IDX_CFG_STAT) && rd_event_snap_q[1];
	reg  [7:0]  rd_mux;
	reg         map_hit;
	always @* begin
		rd_mux  = 8'h00;
		map_hit = idx_ok;
		case (idx)
			`RXL_IDX_DATA0:    rd_mux = ind_data_q[7:0];
			`RXL_IDX_DATA1:    rd_mux = ind_data_q[15:8];
			`RXL_IDX_DATA2:    rd_mux = ind_data_q[23:16];
			`RXL_IDX_DATA3:    rd_mux = ind_data_q[31:24];
			`RXL_IDX_SYS_CTRL: rd_mux = {6'h00, master_quiescent_test_q, rx_iface_powerdown_q};
			`RXL_IDX_CFG_STAT: rd_mux = {sig_loss_event_q, sig_loss_state_q, sig_loss_irq_enable_q,
			                             zero_data_on_loss_enable_q, rx_quiescent_test_enable_q,
			                             equalizer_stable_q, 1'b0, cfg_reserved_q};
			`RXL_IDX_THR_SEL:  rd_mux = {1'b0, loss_release_threshold_q, 1'b0, loss_declare_threshold_q};
			`RXL_IDX_LOSS_DECLARE_PERIOD:  rd_mux = loss_declare_period_q;
			`RXL_IDX_LOSS_RELEASE_PERIOD:  rd_mux = loss_release_period_q;
			`RXL_IDX_EQ_RAM_INDEX:  rd_mux = eq_ram_index_q;
			`RXL_IDX_EQ_DIR:   rd_mux = {ram_read_not_write_q, 7'h00};
			`RXL_IDX_EQ_LOC:   rd_mux = eq_location_q;
			`RXL_IDX_EQ_CFG:   rd_mux = eq_cfg_q;
			default:           map_hit = 1'b0;
		endcase
	end

	// no wait state: ready, read data and error are captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata          <= 32'h00000000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			rd_event_snap_q <= 2'b00;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata          <= map_hit ? {24'h000000, rd_mux} : 32'h00000000;
				pslverr         <= ~map_hit;
				rd_event_snap_q <= {sig_loss_change_q, sig_loss_event_q} & {2{map_hit && (idx == `RXL_IDX_CFG_STAT)}};
			end
		end
	end

	// ==========================================================
	// system control, outside the powerdown reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_iface_powerdown_q    <= 1'b0;
			master_quiescent_test_q <= 1'b0;
		end else if (wr_en && (idx == `RXL_IDX_SYS_CTRL)) begin
			rx_iface_powerdown_q    <= wb[`RXL_SC_PWRDN];
			master_quiescent_test_q <= wb[`RXL_SC_MASTER_IDDQ];
		end
	end

	// ==========================================================
	// configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_loss_irq_enable_q      <= 1'b0;
			zero_data_on_loss_enable_q <= 1'b0;
			rx_quiescent_test_enable_q <= 1'b0;
			cfg_reserved_q             <= `RXL_RST_CFG_RSVD;
			loss_declare_threshold_q   <= 3'h0;
			loss_release_threshold_q   <= 3'h0;
			loss_declare_period_q      <= `RXL_RST_PERIOD;
			loss_release_period_q      <= `RXL_RST_PERIOD;
			ram_read_not_write_q       <= `RXL_RST_READ_SEL;
			eq_cfg_q                   <= `RXL_RST_EQ_CFG;
		end else if (rx_iface_powerdown_q) begin
			sig_loss_irq_enable_q      <= 1'b0;
			zero_data_on_loss_enable_q <= 1'b0;
			rx_quiescent_test_enable_q <= 1'b0;
			cfg_reserved_q             <= `RXL_RST_CFG_RSVD;
			loss_declare_threshold_q   <= 3'h0;
			loss_release_threshold_q   <= 3'h0;
			loss_declare_period_q      <= `RXL_RST_PERIOD;
			loss_release_period_q      <= `RXL_RST_PERIOD;
			ram_read_not_write_q       <= `RXL_RST_READ_SEL;
			eq_cfg_q                   <= `RXL_RST_EQ_CFG;
		end else if (wr_en) begin
			if (idx == `RXL_IDX_CFG_STAT) begin
				sig_loss_irq_enable_q      <= wb[`RXL_CS_IRQ_EN];
				zero_data_on_loss_enable_q <= wb[`RXL_CS_SQUELCH];
				rx_quiescent_test_enable_q <= wb[`RXL_CS_IDDQ];
				cfg_reserved_q             <= wb[`RXL_CS_RSVD];
			end
			if (idx == `RXL_IDX_THR_SEL) begin
				loss_declare_threshold_q <= wb[2:0];
				loss_release_threshold_q <= wb[6:4];
			end
			if (idx == `RXL_IDX_LOSS_DECLARE_PERIOD)
				loss_declare_period_q <= wb;
			if (idx == `RXL_IDX_LOSS_RELEASE_PERIOD)
				loss_release_period_q <= wb;
			if (idx == `RXL_IDX_EQ_DIR)
				ram_read_not_write_q <= wb[`RXL_DIR_READ];
			if (idx == `RXL_IDX_EQ_CFG)
				eq_cfg_q <= {wb[7:6], 2'b00, wb[3:0]};
		end
	end

	// ==========================================================
	// loss-of-signal detection and clearance
	function [6:0] thr_half_db;
		input [2:0] code;
		begin
			case (code)
				3'h0:    thr_half_db = 7'h12;
				3'h1:    thr_half_db = 7'h1D;
				3'h2:    thr_half_db = 7'h28;
				3'h3:    thr_half_db = 7'h2C;
				3'h4:    thr_half_db = 7'h32;
				3'h5:    thr_half_db = 7'h3C;
				3'h6:    thr_half_db = 7'h3E;
				default: thr_half_db = 7'h46;
			endcase
		end
	endfunction

	wire [6:0]  det_level = thr_half_db(loss_declare_threshold_q);
	wire [6:0]  clr_level = thr_half_db(loss_release_threshold_q);
	wire        qualify   = sig_loss_state_q ? (level_s >= clr_level) : (level_s <= det_level);
	wire [11:0] persist_n = sig_loss_state_q ? {loss_release_period_q, 4'h0} : {loss_declare_period_q, 4'h0};
	wire [11:0] cnt_inc   = persist_cnt_q + 12'h001;
	wire        flip      = line_pulse && qualify && (cnt_inc >= persist_n);
	wire        loss_rise = flip && !sig_loss_state_q;
	wire        sig_loss_event_d  = loss_rise | (sig_loss_event_q & ~clr_evt);
	wire        sig_loss_change_d = flip | (sig_loss_change_q & ~clr_chg);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			persist_cnt_q    <= 12'h000;
			sig_loss_state_q <= 1'b0;
			sig_loss_event_q <= 1'b0;
			sig_loss_change_q <= 1'b0;
		end else if (rx_iface_powerdown_q) begin
			persist_cnt_q    <= 12'h000;
			sig_loss_state_q <= 1'b0;
			sig_loss_event_q <= 1'b0;
			sig_loss_change_q <= 1'b0;
		end else begin
			sig_loss_event_q <= sig_loss_event_d;
			sig_loss_change_q <= sig_loss_change_d;
			if (line_pulse) begin
				if (flip) begin
					sig_loss_state_q <= ~sig_loss_state_q;
					persist_cnt_q    <= 12'h000;
				end else if (qualify)
					persist_cnt_q <= cnt_inc;
				else
					persist_cnt_q <= 12'h000;
			end
		end
	end

	// ==========================================================
	// equalizer stability
	wire [7:0]  est_diff   = (estimate_s >= stable_ref_q) ? (estimate_s - stable_ref_q) : (stable_ref_q - estimate_s);
	wire [8:0]  stable_n   = `RXL_STABLE_BASE << eq_cfg_q[7:6];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_ref_q       <= 8'h00;
			stable_cnt_q       <= 9'h000;
			equalizer_stable_q <= 1'b0;
		end else if (rx_iface_powerdown_q) begin
			stable_ref_q       <= 8'h00;
			stable_cnt_q       <= 9'h000;
			equalizer_stable_q <= 1'b0;
		end else if (eq_pulse) begin
			if (est_diff > `RXL_STABLE_STEPS) begin
				stable_ref_q       <= estimate_s;
				stable_cnt_q       <= 9'h000;
				equalizer_stable_q <= 1'b0;
			end else begin
				if (stable_cnt_q != 9'h1FF)
					stable_cnt_q <= stable_cnt_q + 9'h001;
				equalizer_stable_q <= (stable_cnt_q >= stable_n);
			end
		end
	end

	// ==========================================================
	// equalization ram indirect access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_ram_index_q   <= 8'h00;
			access_pending_q <= 1'b0;
			eq_location_q    <= 8'h00;
			ind_data_q       <= 32'h00000000;
		end else if (rx_iface_powerdown_q) begin
			eq_ram_index_q   <= 8'h00;
			access_pending_q <= 1'b0;
			eq_location_q    <= 8'h00;
			ind_data_q       <= 32'h00000000;
		end else begin
			access_pending_q <= wr_en && (idx == `RXL_IDX_EQ_RAM_INDEX);
			if (wr_en && (idx == `RXL_IDX_EQ_RAM_INDEX))
				eq_ram_index_q <= wb;
			if (wr_en && (idx == `RXL_IDX_EQ_LOC))
				eq_location_q <= wb;
			if (access_pending_q && ram_read_not_write_q)
				ind_data_q <= eq_ram_q[eq_ram_index_q];
			else if (wr_en) begin
				if (idx == `RXL_IDX_DATA0)
					ind_data_q[7:0] <= wb;
				if (idx == `RXL_IDX_DATA1)
					ind_data_q[15:8] <= wb;
				if (idx == `RXL_IDX_DATA2)
					ind_data_q[23:16] <= wb;
				if (idx == `RXL_IDX_DATA3)
					ind_data_q[31:24] <= wb;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 256; gi = gi + 1) begin : g_ram
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					eq_ram_q[gi] <= 32'h00000000;
				else if (access_pending_q && !ram_read_not_write_q && ({24'h000000, eq_ram_index_q} == gi))
					eq_ram_q[gi] <= ind_data_q;
			end
		end
	endgenerate

	// ==========================================================
	// outputs
	wire quiescent = rx_quiescent_test_enable_q | master_quiescent_test_q;
	wire squelch   = zero_data_on_loss_enable_q & sig_loss_state_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n             <= 1'b1;
			rx_data_out       <= 1'b0;
			rx_quiescent_test <= 1'b0;
			eq_feedback_freq  <= 3'h0;
			eq_ram_word       <= 32'h00000000;
		end else begin
			irq_n             <= ~(sig_loss_irq_enable_q & (sig_loss_event_q | sig_loss_change_q));
			rx_data_out       <= (quiescent | squelch) ? 1'b0 : rx_data_s;
			rx_quiescent_test <= quiescent;
			eq_feedback_freq  <= quiescent ? 3'h0 : eq_cfg_q[2:0];
			eq_ram_word       <= quiescent ? 32'h00000000 : eq_ram_q[eq_location_q];
		end
	end

endmodule
`default_nettype wire

// ### verif/rxl_front_end_model.sv
// analog receive front end model: pulse and loop ticks, level, data, estimate
// assumes: the bench steers level, estimate and loop ticks in step with pclk
`timescale 1ns/100ps
`default_nettype none
module rxl_front_end_model (
	input  wire logic       pclk,
	input  wire logic       eq_run,
	input  wire logic [6:0] level,
	input  wire logic [7:0] est_base,
	output var  logic       line_tick_in,
	output var  logic       eq_tick_in,
	output var  logic [6:0] sig_level_in,
	output var  logic       rx_data_in,
	output var  logic [7:0] cable_attenuation_estimate
);
	logic [2:0] cnt_q;
	integer     seed;
	initial begin
		cnt_q = 3'h0;
		seed = 64;
		line_tick_in = 1'b0;
		eq_tick_in = 1'b0;
		sig_level_in = 7'h7F;
		rx_data_in = 1'b0;
		cable_attenuation_estimate = 8'h40;
	end
	// level moves mid low phase so it is steady around each tick
	always @(posedge pclk) begin
		cnt_q <= cnt_q + 3'h1;
		line_tick_in <= cnt_q[2];
		eq_tick_in <= cnt_q[2] & eq_run;
		if (cnt_q == 3'h1) sig_level_in <= level;
		rx_data_in <= 1'($random(seed));
		cable_attenuation_estimate <= est_base + {6'h00, cnt_q[1:0]};
	end
endmodule
`default_nettype wire

// ### verif/rxl_los_eq_sva.sv
// port checker of the receive line block
// assumes: bound to the design top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module rxl_los_eq_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq_n,
	input wire logic        rx_data_out,
	input wire logic        rx_quiescent_test,
	input wire logic [2:0]  eq_feedback_freq,
	input wire logic [31:0] eq_ram_word
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// bus timing
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer one cycle after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
		else $error("error answer carries data");
	a_rdata_holds: assert property (!pready |-> $stable(prdata))
		else $error("read data moved outside answer");
	a_reset_release: assert property ($rose(presetn) |-> irq_n && !pready)
		else $error("outputs not idle after reset");
	// ==========================================================
	// quiescent test
	a_test_data_low: assert property (rx_quiescent_test && $past(rx_quiescent_test) |-> !rx_data_out)
		else $error("data not low in quiescent test");
	a_test_eq_low: assert property (rx_quiescent_test && $past(rx_quiescent_test)
		|-> eq_feedback_freq == 3'h0 && eq_ram_word == 32'h00000000)
		else $error("eq outputs not low in quiescent test");
	c_read: cover property (pready && !pwrite);
	c_error: cover property (pready && pslverr);
	c_irq: cover property ($fell(irq_n));
endmodule
`default_nettype wire

// ### verif/test_rx_line_los_and_eq_ram_access.sv
// self-checking bench: apb master with expectation queue, front end model
// assumes: rxl_map.vh on the include path; checker bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "rxl_map.vh"
`define CHK(nm, ex, got) \
	begin \
		compares++; \
		if ((got) !== (ex)) begin \
			num_errors++; \
			$display("mismatch %s expected %h seen %h", nm, ex, got); \
		end \
	end
module test_rx_line_los_and_eq_ram_access;
	logic        pclk, presetn, psel, penable, pwrite, eq_run, seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, eq_ram_word;
	logic        pready, pslverr, irq_n, rx_data_out, rx_quiescent_test;
	logic        line_tick_in, eq_tick_in, rx_data_in;
	logic [2:0]  eq_feedback_freq;
	logic [6:0]  sig_level_in, level;
	logic [7:0]  cable_attenuation_estimate, est_base, v;
	logic [7:0]  d [4];
	logic [7:0]  rst_tab [8] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h03};
	logic [9:0]  exp_q [$];
	logic [9:0]  e;
	int          num_errors = 0, compares = 0, cyc = 0, seed = 64;
	rxl_los_eq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_tick_in(line_tick_in), .sig_level_in(sig_level_in), .rx_data_in(rx_data_in),
		.eq_tick_in(eq_tick_in), .cable_attenuation_estimate(cable_attenuation_estimate), .irq_n(irq_n),
		.rx_data_out(rx_data_out), .rx_quiescent_test(rx_quiescent_test),
		.eq_feedback_freq(eq_feedback_freq), .eq_ram_word(eq_ram_word));
	rxl_front_end_model u_fe (.pclk(pclk), .eq_run(eq_run), .level(level), .est_base(est_base),
		.line_tick_in(line_tick_in), .eq_tick_in(eq_tick_in), .sig_level_in(sig_level_in),
		.rx_data_in(rx_data_in), .cable_attenuation_estimate(cable_attenuation_estimate));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic end_of_test();
		$display("counts: %0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// apb master: one transfer, expectation queued first
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dat, input logic [7:0] ex,
		input logic er);
		exp_q.push_back({~w, er, ex});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, dat};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		apb(1'b1, {2'b00, idx, 2'b00}, dat, 8'h00, 1'b0);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
		apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, ex, 1'b0);
	endtask
	// ==========================================================
	// answer watcher
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end else if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			`CHK("pslverr", e[8], pslverr)
			if (e[9]) `CHK("prdata", {24'h000000, e[7:0]}, prdata)
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		eq_run = 1'b0;
		level = 7'h7F;
		est_base = 8'h40;
		seen = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'hF8 + 8'(i), rst_tab[i]);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(`RXL_IDX_THR_SEL, v);
			rd(`RXL_IDX_THR_SEL, v & 8'h77);
			wr(`RXL_IDX_LOSS_DECLARE_PERIOD, v);
			rd(`RXL_IDX_LOSS_DECLARE_PERIOD, v);
		end
		wr(`RXL_IDX_LOSS_DECLARE_PERIOD, 8'h01);
		apb(1'b0, 12'h040, 8'h00, 8'h00, 1'b1);
		apb(1'b1, 12'h3E1, 8'h5A, 8'h00, 1'b1);
		apb(1'b0, 12'hBE0, 8'h00, 8'h00, 1'b1);
		$display("test register access done");
		for (int i = 0; i < 4; i++) begin
			d[i] = 8'($random(seed));
			wr(`RXL_IDX_DATA0 + 8'(i), d[i]);
		end
		wr(`RXL_IDX_EQ_DIR, 8'h00);
		wr(`RXL_IDX_EQ_RAM_INDEX, 8'h5A);
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 4; i++) wr(`RXL_IDX_DATA0 + 8'(i), 8'h00);
		wr(`RXL_IDX_EQ_DIR, 8'h80);
		wr(`RXL_IDX_EQ_RAM_INDEX, 8'h5A);
		repeat (3) @(posedge pclk);
		for (int i = 0; i < 4; i++) rd(`RXL_IDX_DATA0 + 8'(i), d[i]);
		wr(`RXL_IDX_EQ_LOC, 8'h5A);
		repeat (3) @(posedge pclk);
		`CHK("eq_ram_word", {d[3], d[2], d[1], d[0]}, eq_ram_word)
		$display("test eq ram done");
		wr(`RXL_IDX_THR_SEL, 8'h77);
		wr(`RXL_IDX_CFG_STAT, 8'h21);
		level <= 7'd70;
		repeat (100) @(posedge pclk);
		`CHK("irq_n early", 1'b1, irq_n)
		for (int k = 0; k < 150 && irq_n !== 1'b0; k++) @(posedge pclk);
		`CHK("irq_n", 1'b0, irq_n)
		level <= 7'd0;
		rd(`RXL_IDX_CFG_STAT, 8'hE1);
		rd(`RXL_IDX_CFG_STAT, 8'h61);
		@(posedge pclk);
		`CHK("irq_n release", 1'b1, irq_n)
		wr(`RXL_IDX_CFG_STAT, 8'h31);
		@(posedge pclk);
		repeat (40) begin @(posedge pclk); `CHK("rx_data_out", 1'b0, rx_data_out) end
		level <= 7'd70;
		repeat (200) @(posedge pclk);
		`CHK("irq_n on clearance", 1'b0, irq_n)
		rd(`RXL_IDX_CFG_STAT, 8'h31);
		repeat (2) @(posedge pclk);
		`CHK("irq_n clearance release", 1'b1, irq_n)
		level <= 7'h7F;
		repeat (40) begin @(posedge pclk); seen = seen | rx_data_out; end
		`CHK("rx_data_out passes", 1'b1, seen)
		$display("test signal loss done");
		wr(`RXL_IDX_CFG_STAT, 8'h09);
		repeat (3) @(posedge pclk);
		`CHK("quiescent", 1'b1, rx_quiescent_test)
		wr(`RXL_IDX_CFG_STAT, 8'h01);
		wr(`RXL_IDX_SYS_CTRL, 8'h02);
		repeat (3) @(posedge pclk);
		`CHK("master quiescent", 1'b1, rx_quiescent_test)
		wr(`RXL_IDX_SYS_CTRL, 8'h00);
		repeat (3) @(posedge pclk);
		`CHK("eq_feedback_freq", 3'h3, eq_feedback_freq)
		wr(`RXL_IDX_SYS_CTRL, 8'h01);
		wr(`RXL_IDX_LOSS_RELEASE_PERIOD, 8'h33);
		rd(`RXL_IDX_LOSS_RELEASE_PERIOD, 8'h01);
		wr(`RXL_IDX_SYS_CTRL, 8'h00);
		rd(`RXL_IDX_EQ_LOC, 8'h00);
		$display("test quiescent and powerdown done");
		eq_run <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(`RXL_IDX_EQ_CFG, {c[1:0], 6'h03});
			est_base <= est_base + 8'h20;
			repeat (((32 << c) - 4) * 8) @(posedge pclk);
			rd(`RXL_IDX_CFG_STAT, 8'h01);
			repeat (80) @(posedge pclk);
			rd(`RXL_IDX_CFG_STAT, 8'h05);
		end
		$display("test equalizer stable done");
		end_of_test();
	end
endmodule
bind rxl_los_eq rxl_los_eq_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq_n(irq_n), .rx_data_out(rx_data_out), .rx_quiescent_test(rx_quiescent_test),
	.eq_feedback_freq(eq_feedback_freq), .eq_ram_word(eq_ram_word));
`default_nettype wire
